// ===== testbench/gp_pin_model.sv
`timescale 1ns/10ps
`default_nettype none
module gp_pin_model (
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] ext_lvl,
    output logic [7:0] pin_lvl
);
    // Driven bits follow the port, released bits follow the outside board
    assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule
`default_nettype wire

// ===== testbench/gp_ports_tb.sv
`timescale 1ns/10ps
`default_nettype none
module gp_ports_tb;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0] s_axi_awaddr, s_axi_araddr, ext3, ext5, ext7, dir, dat, pu, md;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic [7:0] p3_pin_in, p3_pin_out, p3_pin_oe, p5_pin_in, p5_pin_out, p5_pin_oe, p5_pullup_on;
    logic [7:0] p7_pin_in, p7_pin_out, p7_pin_oe;
    logic i2c_scl_o, i2c_sda_o, i2c_scl_i, i2c_sda_i, timer_v_output, timer_v_clock_input;
    logic timer_v_reset_input, serial2_txd, serial2_rxd, serial2_sck_o, serial2_sck_i;
    logic [5:0] wake_in;
    int seed, error_cnt, total_checks;
    // Device and the board around its three ports
    gp_ports dut_u (.*);
    gp_pin_model p3_u (.pin_oe(p3_pin_oe), .pin_out(p3_pin_out), .ext_lvl(ext3), .pin_lvl(p3_pin_in));
    gp_pin_model p5_u (.pin_oe(p5_pin_oe), .pin_out(p5_pin_out), .ext_lvl(ext5), .pin_lvl(p5_pin_in));
    gp_pin_model p7_u (.pin_oe(p7_pin_oe), .pin_out(p7_pin_out), .ext_lvl(ext7), .pin_lvl(p7_pin_in));
    // Clock and watchdog
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    initial begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        complete_run();
    end
    // ----------------------------------------
    // Bus tasks and checks
    // ----------------------------------------
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        rr = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axr(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        axr(a);
        chk(rd[7:0], e);
    endtask
    task automatic settle();
        repeat (2) @(posedge aclk);
        #1;
    endtask
    // Data read: stored bit when output, pin level when input
    function automatic logic [7:0] rd_exp(input logic [7:0] d, input logic [7:0] v, input logic [7:0] p);
        return (d & v) | (~d & p);
    endfunction
    task automatic complete_run();
        $display("Checks %0d, errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        seed = 32'hb74a87a2;
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hf;
        {i2c_scl_o, i2c_sda_o, timer_v_output, serial2_txd, serial2_sck_o} = 5'h18;
        {ext3, ext5, ext7} = 24'ha5c35a;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        #1 chk(p3_pin_oe | p5_pin_oe | p7_pin_oe | p5_pullup_on, 8'h00);
        rdchk(8'h08, 8'h00);
        rdchk(8'h1c, (ext7 & 8'hf7) | 8'h08);
        for (int i = 0; i < 12; i++) begin
            dir = 8'($random(seed));
            dat = 8'($random(seed));
            pu = 8'($random(seed));
            md = {2'b00, 6'($random(seed))};
            ext3 <= 8'($random(seed));
            ext5 <= 8'($random(seed));
            axw(8'h00, {24'h0, dir});
            axw(8'h04, {24'h0, dat});
            axw(8'h08, {24'h0, md});
            axw(8'h0c, {24'h0, dir});
            axw(8'h10, {24'h0, dat});
            axw(8'h14, {24'h0, pu});
            settle();
            chk(p3_pin_oe, dir);
            chk(p3_pin_out & dir, dat & dir);
            rdchk(8'h04, rd_exp(dir, dat, ext3));
            chk(p5_pin_oe, dir & ~md);
            chk(p5_pullup_on, pu & ~dir & 8'h3f);
            chk({2'b00, wake_in}, {2'b00, md[5:0] & ext5[5:0]});
            rdchk(8'h10, rd_exp(dir, dat, ext5));
            rdchk(8'h14, pu & 8'h3f);
        end
        // Open drain, then the I2C unit takes the two top pins
        axw(8'h08, 32'hc0);
        axw(8'h0c, 32'hc0);
        axw(8'h10, 32'h80);
        settle();
        chk({5'h0, p5_pin_oe[7:6], p5_pin_out[6]}, 8'h02);
        i2c_scl_o <= 1'b0;
        axw(8'h20, 32'h1);
        settle();
        chk({4'h0, p5_pin_oe[7:6], p5_pin_out[7], i2c_scl_i}, 8'h08);
        chk({7'h0, i2c_sda_i}, {7'h0, ext5[6]});
        // Port 7 with timer and serial pins claimed
        axw(8'h18, 32'hff);
        axw(8'h1c, 32'h30);
        settle();
        chk({5'h0, p7_pin_oe[3], timer_v_clock_input, timer_v_reset_input}, 8'h03);
        rdchk(8'h1c, 8'h38);
        {timer_v_output, serial2_txd, serial2_sck_o} <= 3'h7;
        axw(8'h20, 32'h518);
        settle();
        chk({p7_pin_oe[6], p7_pin_out[6], p7_pin_oe[2], p7_pin_out[2], p7_pin_oe[1:0], serial2_rxd, serial2_sck_i},
            {6'b111100, ext7[1], ext7[0]});
        axw(8'h20, 32'h200);
        settle();
        chk({5'h0, p7_pin_out[6], p7_pin_oe[0], p7_pin_out[0]}, 8'h03);
        axw(8'h20, 32'h800);
        chk({6'h0, rr}, 8'h00);
        settle();
        chk({6'h0, p7_pin_oe[0], p7_pin_out[0]}, 8'h03);
        axr(8'h24);
        chk({6'h0, rr}, 8'h02);
        axw(8'h24, 32'h0);
        chk({6'h0, rr}, 8'h02);
        complete_run();
    end
endmodule
`default_nettype wire

// ===== verilog/gp_axil_slave.sv
`timescale 1ns/10ps
`default_nettype none
`include "gp_consts.svh"
module gp_axil_slave
    import gp_pkg::*;
#(
    parameter int ADDR_W = `GP_ADDR_W
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    gp_reg_if.slv rb
);
    gp_wr_state_t wr_state_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    // ----------------------------------------
    // Decode
    // ----------------------------------------
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire ar_take = s_axi_arvalid && s_axi_arready;
    wire aw_ok = aw_addr_q[1:0] == 2'h0 && aw_addr_q[ADDR_W-1:6] == '0 && aw_addr_q[5:2] <= `GP_IDX_MAX;
    wire ar_ok = s_axi_araddr[1:0] == 2'h0 && s_axi_araddr[ADDR_W-1:6] == '0 && s_axi_araddr[5:2] <= `GP_IDX_MAX;
    wire wr_go = wr_state_q == GP_WR_COLLECT && !s_axi_awready && !s_axi_wready;
    assign rb.wr_en = wr_go && aw_ok;
    assign rb.wr_idx = aw_addr_q[5:2];
    assign rb.wr_data = w_data_q;
    assign rb.wr_strb = w_strb_q;
    assign rb.rd_idx = s_axi_araddr[5:2];
    // ----------------------------------------
    // Write channels, both held until response taken
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state_q <= GP_WR_COLLECT;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `GP_RESP_OKAY;
            aw_addr_q <= '0;
            w_data_q <= 32'h0;
            w_strb_q <= 4'h0;
        end else begin
            if (aw_take) begin
                s_axi_awready <= 1'b0;
                aw_addr_q <= s_axi_awaddr;
            end
            if (w_take) begin
                s_axi_wready <= 1'b0;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            case (wr_state_q)
                GP_WR_COLLECT: begin
                    if (wr_go) begin
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp <= aw_ok ? `GP_RESP_OKAY : `GP_RESP_SLVERR;
                        wr_state_q <= GP_WR_RESP;
                    end
                end
                GP_WR_RESP: begin
                    if (s_axi_bready) begin
                        s_axi_bvalid <= 1'b0;
                        s_axi_awready <= 1'b1;
                        s_axi_wready <= 1'b1;
                        wr_state_q <= GP_WR_COLLECT;
                    end
                end
                default: wr_state_q <= GP_WR_COLLECT;
            endcase
        end
    end
    // ----------------------------------------
    // Read channel, data one cycle after address
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `GP_RESP_OKAY;
        end else if (ar_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= ar_ok ? rb.rd_data : 32'h0;
            s_axi_rresp <= ar_ok ? `GP_RESP_OKAY : `GP_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ===== verilog/gp_consts.svh
`ifndef GP_CONSTS_SVH
`define GP_CONSTS_SVH
// ----------------------------------------
// Register word indexes, byte address = index * 4
// ----------------------------------------
`define GP_IDX_P3_DIR 4'h0
`define GP_IDX_P3_DAT 4'h1
`define GP_IDX_P5_MODE 4'h2
`define GP_IDX_P5_DIR 4'h3
`define GP_IDX_P5_DAT 4'h4
`define GP_IDX_P5_PU 4'h5
`define GP_IDX_P7_DIR 4'h6
`define GP_IDX_P7_DAT 4'h7
`define GP_IDX_ALT 4'h8
`define GP_IDX_MAX 4'h8
`define GP_ADDR_W 8
// ----------------------------------------
// Reset values and masks
// ----------------------------------------
`define GP_RST_BYTE 8'h00
`define GP_RST_ALT 12'h000
`define GP_P5_PU_MASK 8'h3f
`define GP_P7_DIR_MASK 8'hf7
`define GP_P7_RSVD_ONES 8'h08
// ----------------------------------------
// Alternate function control fields
// ----------------------------------------
`define GP_ALT_I2C_EN 0
`define GP_ALT_SERIAL2_TRANSMIT_PIN_SEL 3
`define GP_ALT_OS_LSB 4
`define GP_ALT_OS_MSB 7
`define GP_ALT_RE 8
`define GP_ALT_CKE_LO 9
`define GP_ALT_CKE_HI 10
`define GP_ALT_SYNC 11
// ----------------------------------------
// Bus responses
// ----------------------------------------
`define GP_RESP_OKAY 2'h0
`define GP_RESP_SLVERR 2'h2
`endif

// ===== verilog/gp_pkg.sv
package gp_pkg;
    typedef logic [7:0] gp_byte_t;
    typedef logic [3:0] gp_idx_t;
    typedef enum logic {GP_WR_COLLECT, GP_WR_RESP} gp_wr_state_t;
endpackage

// ===== verilog/gp_ports.sv
// Notes on behaviour
// - A port 3 pin is driven when its direction bit is 1 and is an input when it is 0.
// - A port 5 general pin is an output when its direction bit is 1 and an input when 0.
// - Written data is held per port and driven onto general-purpose output pins.
// - Reading a data bit whose direction bit is 1 returns the stored value.
// - Reading a data bit whose direction bit is 0 returns the sampled pin level.
// - Port 5 mode bits 7 and 6 make their pins open-drain when 1 and push-pull when 0.
// - Port 5 mode bits 5 to 0 make their pins wake inputs when 1, ignoring direction.
// - Port 5 pull-up bits 5 to 0 turn the pull-up on only while the direction bit is 0.
// - Port 5 pull-up bits 7 and 6 always read as 0.
// - With the I2C unit enabled, port 5 pins 7 and 6 become clock and data lines.
// - Those I2C lines only ever drive low.
// - Port 7 direction exists for pins 7 to 4 and 2 to 0; position 3 is reserved.
// - Port 7 data bit 3 always reads as 1.
// - Timer and serial settings override port 7 direction on pins 6, 2, 1 and 0.
// - Port 7 pins 5 and 4 always feed the timer clock and reset inputs.
// - The transmit select bit turns port 7 pin 2 into the serial transmit output.
//
// The AXI4-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "gp_consts.svh"
module gp_ports
    import gp_pkg::*;
#(
    parameter int ADDR_W = `GP_ADDR_W
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] p3_pin_in,
    output logic [7:0] p3_pin_out,
    output logic [7:0] p3_pin_oe,
    input wire logic [7:0] p5_pin_in,
    output logic [7:0] p5_pin_out,
    output logic [7:0] p5_pin_oe,
    output logic [7:0] p5_pullup_on,
    input wire logic [7:0] p7_pin_in,
    output logic [7:0] p7_pin_out,
    output logic [7:0] p7_pin_oe,
    input wire logic i2c_scl_o,
    input wire logic i2c_sda_o,
    output logic i2c_scl_i,
    output logic i2c_sda_i,
    output logic [5:0] wake_in,
    input wire logic timer_v_output,
    output logic timer_v_clock_input,
    output logic timer_v_reset_input,
    input wire logic serial2_txd,
    output logic serial2_rxd,
    input wire logic serial2_sck_o,
    output logic serial2_sck_i
);
    gp_reg_if rb ();
    // ----------------------------------------
    // Bus slave
    // ----------------------------------------
    gp_axil_slave #(.ADDR_W(ADDR_W)) u_slave (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .rb(rb.slv)
    );
    // ----------------------------------------
    // Registers
    // ----------------------------------------
    gp_byte_t port3_direction_q;
    gp_byte_t port3_output_data_q;
    gp_byte_t port5_mode_select_q;
    gp_byte_t port5_direction_q;
    gp_byte_t port5_output_data_q;
    gp_byte_t port5_pullup_enable_q;
    gp_byte_t port7_direction_q;
    gp_byte_t port7_output_data_q;
    logic [11:0] alt_ctrl_q;
    gp_byte_t p3_in_q;
    gp_byte_t p5_in_q;
    gp_byte_t p7_in_q;
    gp_byte_t p5_oe_d;
    gp_byte_t p5_out_d;
    gp_byte_t p5_pu_d;
    gp_byte_t p7_oe_d;
    gp_byte_t p7_out_d;
    // Write strobes per register
    wire wb0 = rb.wr_en && rb.wr_strb[0];
    wire wb1 = rb.wr_en && rb.wr_strb[1];
    wire we_p3_dir = wb0 && rb.wr_idx == `GP_IDX_P3_DIR;
    wire we_p3_dat = wb0 && rb.wr_idx == `GP_IDX_P3_DAT;
    wire we_p5_mode = wb0 && rb.wr_idx == `GP_IDX_P5_MODE;
    wire we_p5_dir = wb0 && rb.wr_idx == `GP_IDX_P5_DIR;
    wire we_p5_dat = wb0 && rb.wr_idx == `GP_IDX_P5_DAT;
    wire we_p5_pu = wb0 && rb.wr_idx == `GP_IDX_P5_PU;
    wire we_p7_dir = wb0 && rb.wr_idx == `GP_IDX_P7_DIR;
    wire we_p7_dat = wb0 && rb.wr_idx == `GP_IDX_P7_DAT;
    wire we_alt_lo = wb0 && rb.wr_idx == `GP_IDX_ALT;
    wire we_alt_hi = wb1 && rb.wr_idx == `GP_IDX_ALT;
    gp_byte_t wbyte;
    assign wbyte = rb.wr_data[7:0];
    // Alternate function settings
    wire i2c_unit_enable = alt_ctrl_q[`GP_ALT_I2C_EN];
    wire serial2_transmit_pin_sel = alt_ctrl_q[`GP_ALT_SERIAL2_TRANSMIT_PIN_SEL];
    wire [3:0] timer_v_output_select = alt_ctrl_q[`GP_ALT_OS_MSB:`GP_ALT_OS_LSB];
    wire receive_enable = alt_ctrl_q[`GP_ALT_RE];
    wire clock_enable_lo = alt_ctrl_q[`GP_ALT_CKE_LO];
    wire clock_enable_hi = alt_ctrl_q[`GP_ALT_CKE_HI];
    wire sync_mode_sel = alt_ctrl_q[`GP_ALT_SYNC];
    wire tmo_on = timer_v_output_select != 4'h0;
    wire sck_out_on = !clock_enable_hi && (clock_enable_lo || sync_mode_sel);
    // Register file updates
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port3_direction_q <= `GP_RST_BYTE;
            port3_output_data_q <= `GP_RST_BYTE;
            port5_mode_select_q <= `GP_RST_BYTE;
            port5_direction_q <= `GP_RST_BYTE;
            port5_output_data_q <= `GP_RST_BYTE;
            port5_pullup_enable_q <= `GP_RST_BYTE;
            port7_direction_q <= `GP_RST_BYTE;
            port7_output_data_q <= `GP_RST_BYTE;
            alt_ctrl_q <= `GP_RST_ALT;
        end else begin
            if (we_p3_dir) port3_direction_q <= wbyte;
            if (we_p3_dat) port3_output_data_q <= wbyte;
            if (we_p5_mode) port5_mode_select_q <= wbyte;
            if (we_p5_dir) port5_direction_q <= wbyte;
            if (we_p5_dat) port5_output_data_q <= wbyte;
            if (we_p5_pu) port5_pullup_enable_q <= wbyte & `GP_P5_PU_MASK;
            if (we_p7_dir) port7_direction_q <= wbyte & `GP_P7_DIR_MASK;
            if (we_p7_dat) port7_output_data_q <= wbyte & `GP_P7_DIR_MASK;
            if (we_alt_lo) alt_ctrl_q[7:0] <= wbyte;
            if (we_alt_hi) alt_ctrl_q[11:8] <= rb.wr_data[11:8];
        end
    end
    // Pin level sampling
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            p3_in_q <= 8'h00;
            p5_in_q <= 8'h00;
            p7_in_q <= 8'h00;
        end else begin
            p3_in_q <= p3_pin_in;
            p5_in_q <= p5_pin_in;
            p7_in_q <= p7_pin_in;
        end
    end
    // ----------------------------------------
    // Read path
    // ----------------------------------------
    // Data reads follow the direction bit per pin
    gp_byte_t p3_rd;
    gp_byte_t p5_rd;
    gp_byte_t p7_rd;
    assign p3_rd = (port3_direction_q & port3_output_data_q) | (~port3_direction_q & p3_in_q);
    assign p5_rd = (port5_direction_q & port5_output_data_q) | (~port5_direction_q & p5_in_q);
    assign p7_rd = (port7_direction_q & port7_output_data_q) | (~port7_direction_q & p7_in_q)
        | `GP_P7_RSVD_ONES;
    // Register select, write-only registers read zero
    gp_byte_t rd_byte;
    assign rd_byte = rb.rd_idx == `GP_IDX_P3_DAT ? p3_rd :
        rb.rd_idx == `GP_IDX_P5_MODE ? port5_mode_select_q :
        rb.rd_idx == `GP_IDX_P5_DAT ? p5_rd :
        rb.rd_idx == `GP_IDX_P5_PU ? port5_pullup_enable_q :
        rb.rd_idx == `GP_IDX_P7_DAT ? p7_rd :
        rb.rd_idx == `GP_IDX_ALT ? alt_ctrl_q[7:0] : 8'h00;
    assign rb.rd_data = {20'h00000, rb.rd_idx == `GP_IDX_ALT ? alt_ctrl_q[11:8] : 4'h0, rd_byte};
    // ----------------------------------------
    // Port 5 pin control
    // ----------------------------------------
    genvar k;
    generate
        for (k = 0; k < 8; k++) begin : g_p5
            if (k >= 6) begin : g_i2c
                // I2C takes the pin, low-only drive
                wire drv = (k == 7) ? i2c_scl_o : i2c_sda_o;
                wire od = port5_mode_select_q[k];
                assign p5_oe_d[k] = i2c_unit_enable ? !drv :
                    port5_direction_q[k] && !(od && port5_output_data_q[k]);
                assign p5_out_d[k] = i2c_unit_enable ? 1'b0 : port5_output_data_q[k];
                assign p5_pu_d[k] = 1'b0;
            end else begin : g_gen
                // Wake mode forces input
                assign p5_oe_d[k] = !port5_mode_select_q[k] && port5_direction_q[k];
                assign p5_out_d[k] = port5_output_data_q[k];
                assign p5_pu_d[k] = port5_pullup_enable_q[k] && !port5_direction_q[k];
            end
        end
    endgenerate
    // ----------------------------------------
    // Port 7 pin control
    // ----------------------------------------
    // Peripheral settings win over direction
    assign p7_oe_d[7] = port7_direction_q[7];
    assign p7_oe_d[6] = tmo_on || port7_direction_q[6];
    assign p7_oe_d[5:4] = port7_direction_q[5:4];
    assign p7_oe_d[3] = 1'b0;
    assign p7_oe_d[2] = serial2_transmit_pin_sel || port7_direction_q[2];
    assign p7_oe_d[1] = !receive_enable && port7_direction_q[1];
    assign p7_oe_d[0] = !clock_enable_hi && (sck_out_on || port7_direction_q[0]);
    assign p7_out_d[7] = port7_output_data_q[7];
    assign p7_out_d[6] = tmo_on ? timer_v_output : port7_output_data_q[6];
    assign p7_out_d[5:3] = port7_output_data_q[5:3];
    assign p7_out_d[2] = serial2_transmit_pin_sel ? serial2_txd : port7_output_data_q[2];
    assign p7_out_d[1] = port7_output_data_q[1];
    assign p7_out_d[0] = sck_out_on ? serial2_sck_o : port7_output_data_q[0];
    // ----------------------------------------
    // Output flops
    // ----------------------------------------
    // Pin drivers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            p3_pin_oe <= 8'h00;
            p3_pin_out <= 8'h00;
            p5_pin_oe <= 8'h00;
            p5_pin_out <= 8'h00;
            p5_pullup_on <= 8'h00;
            p7_pin_oe <= 8'h00;
            p7_pin_out <= 8'h00;
        end else begin
            p3_pin_oe <= port3_direction_q;
            p3_pin_out <= port3_output_data_q;
            p5_pin_oe <= p5_oe_d;
            p5_pin_out <= p5_out_d;
            p5_pullup_on <= p5_pu_d;
            p7_pin_oe <= p7_oe_d;
            p7_pin_out <= p7_out_d;
        end
    end
    // Feeds to the peripherals, idle levels when not routed
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            i2c_scl_i <= 1'b1;
            i2c_sda_i <= 1'b1;
            wake_in <= 6'h00;
            timer_v_clock_input <= 1'b0;
            timer_v_reset_input <= 1'b0;
            serial2_rxd <= 1'b1;
            serial2_sck_i <= 1'b0;
        end else begin
            i2c_scl_i <= i2c_unit_enable ? p5_pin_in[7] : 1'b1;
            i2c_sda_i <= i2c_unit_enable ? p5_pin_in[6] : 1'b1;
            wake_in <= p5_pin_in[5:0] & port5_mode_select_q[5:0];
            timer_v_clock_input <= p7_pin_in[5];
            timer_v_reset_input <= p7_pin_in[4];
            serial2_rxd <= receive_enable ? p7_pin_in[1] : 1'b1;
            serial2_sck_i <= clock_enable_hi ? p7_pin_in[0] : 1'b0;
        end
    end
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence s_p3_dir_wr;
        we_p3_dir;
    endsequence
    sequence s_p3_dat_wr;
        we_p3_dat;
    endsequence
    a_p3_dir_drive: assert property (s_p3_dir_wr |-> ##2 p3_pin_oe == $past(wbyte, 2))
        else $error("port 3 enable does not follow direction write");
    a_p3_data_out: assert property (s_p3_dat_wr |-> ##2 p3_pin_out == $past(wbyte, 2))
        else $error("port 3 output does not follow data write");
    a_p5_gpio_dir: assert property (!port5_mode_select_q[0] && port5_direction_q[0]
        |=> p5_pin_oe[0])
        else $error("port 5 pin 0 not driven as output");
    a_read_dir_sel: assert property (rb.rd_idx == `GP_IDX_P3_DAT |->
        (rb.rd_data[7:0] & port3_direction_q) == (port3_output_data_q & port3_direction_q))
        else $error("port 3 read mixes wrong sources");
    a_read_pin_lvl: assert property (rb.rd_idx == `GP_IDX_P5_DAT && $past(aresetn)
        |-> (rb.rd_data[7:0] & ~port5_direction_q) == ($past(p5_pin_in) & ~port5_direction_q))
        else $error("port 5 input read not pin level");
    a_p3_input_dir: assert property (!port3_direction_q[0] |=> !p3_pin_oe[0])
        else $error("port 3 input pin driven");
    a_p5_open_drain: assert property (!i2c_unit_enable && port5_mode_select_q[7] && port5_output_data_q[7]
        |=> !p5_pin_oe[7])
        else $error("open-drain pin driving high");
    a_p5_wake_in: assert property (port5_mode_select_q[3] |=> !p5_pin_oe[3] && wake_in[3] == $past(p5_pin_in[3]))
        else $error("wake pin not an input");
    a_p5_pullup: assert property (##1 p5_pullup_on ==
        $past(port5_pullup_enable_q & ~port5_direction_q & `GP_P5_PU_MASK))
        else $error("pull-up enable wrong");
    a_p5_pu_rsvd: assert property (rb.rd_idx == `GP_IDX_P5_PU |-> rb.rd_data[7:6] == 2'h0)
        else $error("reserved pull-up bits not zero");
    a_i2c_low_only: assert property (i2c_unit_enable [*2] |-> p5_pin_out[7:6] == 2'h0
        && p5_pin_oe[7] == !$past(i2c_scl_o))
        else $error("I2C pin drives other than low");
    a_p7_rsvd_one: assert property (rb.rd_idx == `GP_IDX_P7_DAT |-> rb.rd_data[3] && !p7_pin_oe[3])
        else $error("port 7 bit 3 not reserved");
    a_p7_timer_out: assert property (tmo_on |=> p7_pin_oe[6] && p7_pin_out[6] == $past(timer_v_output))
        else $error("timer output not on pin 6");
    a_p7_rx_input: assert property (receive_enable |=> !p7_pin_oe[1])
        else $error("receive pin driven");
    // Serial unit pin claims and timer pin feeds
    sequence s_sck_claim;
        sck_out_on;
    endsequence
    a_p7_sck_out: assert property (s_sck_claim |=> p7_pin_oe[0] && p7_pin_out[0] == $past(serial2_sck_o))
        else $error("clock pin not driven by serial unit");
    a_p7_rx_feed: assert property (receive_enable |=> serial2_rxd == $past(p7_pin_in[1]))
        else $error("receive pin not fed to serial unit");
    a_p7_timer_in: assert property ($past(aresetn) |-> timer_v_clock_input == $past(p7_pin_in[5])
        && timer_v_reset_input == $past(p7_pin_in[4]))
        else $error("timer inputs not fed from pins");
    a_p7_txd_pin: assert property (serial2_transmit_pin_sel |=> p7_pin_oe[2] && p7_pin_out[2] == $past(serial2_txd))
        else $error("transmit pin not routed");
    a_reset_state: assert property ($rose(aresetn) |-> p3_pin_oe == 8'h00 && p5_pullup_on == 8'h00
        && port5_mode_select_q == 8'h00 && port7_direction_q == 8'h00)
        else $error("state not cleared by reset");
endmodule
`default_nettype wire

// ===== verilog/gp_reg_if.sv
`timescale 1ns/10ps
`default_nettype none
interface gp_reg_if;
    import gp_pkg::*;
    logic wr_en;
    gp_idx_t wr_idx;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    gp_idx_t rd_idx;
    logic [31:0] rd_data;
    modport slv (output wr_en, wr_idx, wr_data, wr_strb, rd_idx, input rd_data);
    modport regs (input wr_en, wr_idx, wr_data, wr_strb, rd_idx, output rd_data);
endinterface
`default_nettype wire
